/* File: hw/vic_defs.svh */
`ifndef VIC_DEFS_SVH
`define VIC_DEFS_SVH
// byte offsets of the register map (9-bit window)
`define VIC_OFF_IVP 9'h100
`define VIC_OFF_FVP 9'h104
`define VIC_OFF_CSS 9'h108
`define VIC_OFF_PEND 9'h10C
`define VIC_OFF_MASK 9'h110
`define VIC_OFF_CORE 9'h114
`define VIC_OFF_ENA 9'h120
`define VIC_OFF_DIS 9'h124
`define VIC_OFF_CLR 9'h128
`define VIC_OFF_SET 9'h12C
`define VIC_OFF_EOS 9'h130
`define VIC_OFF_SPV 9'h134
`define VIC_OFF_PROT 9'h138
// region codes in address bits 8:7
`define VIC_RGN_MODE 2'h0
`define VIC_RGN_VEC 2'h1
// mode register fields
`define VIC_MODE_PRIO_LSB 0
`define VIC_MODE_SENSE_LSB 5
// sense bit meanings: bit0 edge, bit1 active high
`define VIC_SENSE_EDGE 0
`define VIC_SENSE_HIGH 1
// sources with programmable polarity
`define VIC_EXT_MASK 32'hF0000001
// reset values
`define VIC_RST_WORD 32'h00000000
`define VIC_RST_SENSE 2'h0
`define VIC_RST_PRIO 3'h0
`define VIC_RST_DEPTH 4'h0
`endif

/* File: hw/vic_pkg.sv */
package vic_pkg;
    // one stacked service level
    typedef struct packed {
        logic [2:0] prio;
        logic [4:0] src;
    } vic_level_s;
    // result of priority resolution
    typedef struct packed {
        logic valid;
        logic [4:0] src;
        logic [2:0] prio;
    } vic_win_s;
    typedef logic [1:0] vic_sense_t;
endpackage

/* File: hw/vic_src.sv */
`include "vic_defs.svh"
module vic_src
    import vic_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // source and configuration
    input wire logic src_i,
    input wire vic_sense_t sense_i,
    input wire logic ext_i,
    // software and acknowledge pulses
    input wire logic set_i,
    input wire logic clr_i,
    input wire logic ack_i,
    // qualified source state
    output logic active_o
);
    logic prev_q; // last sample, for edge detection
    logic edge_q; // latched edge flag
    logic high; // active polarity
    logic hit; // programmed edge seen this cycle

    // internal sources have fixed positive polarity
    assign high = ext_i ? sense_i[`VIC_SENSE_HIGH] : 1'b1;
    assign hit = high ? (src_i & ~prev_q) : (~src_i & prev_q);

    // sample history
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= src_i;
        end
    end

    // edge flag: set wins over any clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            edge_q <= 1'b0;
        end else if (!sense_i[`VIC_SENSE_EDGE]) begin
            edge_q <= 1'b0; // level mode keeps no memory
        end else if (hit || set_i) begin
            edge_q <= 1'b1;
        end else if (clr_i || ack_i) begin
            edge_q <= 1'b0;
        end
    end

    // level mode follows the pin directly
    assign active_o = sense_i[`VIC_SENSE_EDGE] ? edge_q : (src_i == high);
endmodule // vic_src

/* File: hw/vic_ctrl.sv */
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`include "vic_defs.svh"
module vic_ctrl
    import vic_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // interrupt sources, bit 0 is the external fast input
    input wire logic [31:0] src_i,
    // requests to the core, active high
    output logic normal_request_line_o,
    output logic fast_request_line_o
);
    // byte-lane merge, used for the source vector and spurious vector words
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    logic ack_q; // bus answer flag
    logic [31:0] rdata_q; // registered read data
    vic_sense_t sense_q [32]; // sense_select per source
    logic [2:0] prio_q [32]; // priority_level per source
    logic [31:0] vec_q [32]; // source_handler_address per source
    logic [31:0] spur_vec_q; // spurious_handler_address
    logic [31:0] mask_q; // source_mask_status
    logic protect_q; // protect mode enable
    vic_level_s stk_q [8]; // service stack, top is current
    logic [3:0] depth_q; // entries in use, 0..8 in normal mode; repeated protect writes can push it past 8
    logic spur_q; // spurious management in progress
    vic_win_s mem_q; // vector memorized by a protect read
    logic [31:0] active; // per-source qualified state
    logic [31:0] pend; // active and enabled
    logic [31:0] ack_clr; // one-hot edge clear on acknowledge
    vic_win_s win; // resolved winner
    vic_win_s cand; // winner only if it may preempt
    vic_level_s top; // current service level
    logic acc; // first cycle of a bus request
    logic wr; // write access
    logic rd; // read access
    logic [8:0] off; // byte offset inside the block
    logic [4:0] sidx; // source index for per-source regions
    logic is_ivp; // vector port addressed
    logic is_fvp; // fast vector port addressed
    logic nack; // normal-path acknowledge event
    vic_win_s nsel; // entry acknowledged this cycle
    logic fack; // fast vector read
    logic [31:0] ext_mask; // sources whose polarity is programmable

    // bus decode; an access acts only in its first cycle
    assign acc = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr = acc & wb_we_i;
    assign rd = acc & ~wb_we_i;
    assign off = wb_adr_i[8:0];
    assign sidx = wb_adr_i[6:2];
    assign is_ivp = (off == `VIC_OFF_IVP);
    assign is_fvp = (off == `VIC_OFF_FVP);

    // acknowledge: read in normal mode, write in protect mode
    assign nack = is_ivp & (protect_q ? wr : rd);
    assign nsel = protect_q ? mem_q : cand;
    assign fack = rd & is_fvp;
    // one bit per source, picked per instance without a width-losing shift
    assign ext_mask = `VIC_EXT_MASK;

    // source qualification, one instance per source
    for (genvar g = 0; g < 32; g++) begin : g_src
        vic_src u_src (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .src_i((g == 1) ? 1'b0 : src_i[g]),
            .sense_i(sense_q[g]),
            .ext_i(ext_mask[g]),
            .set_i(wr && off == `VIC_OFF_SET && wb_dat_i[g]),
            .clr_i(wr && off == `VIC_OFF_CLR && wb_dat_i[g]),
            .ack_i(ack_clr[g]),
            .active_o(active[g])
        );
    end

    assign pend = active & mask_q;

    // priority resolution over sources 1..31
    always_comb begin
        win = '0;
        for (int i = 1; i < 32; i++) begin
            // strict compare keeps the lower number on a tie
            if (pend[i] && (!win.valid || prio_q[i] > win.prio)) begin
                win = '{valid: 1'b1, src: i[4:0], prio: prio_q[i]};
            end
        end
    end

    // current level and preemption test
    assign top = stk_q[depth_q[2:0] - 3'h1];
    always_comb begin
        cand = win;
        if (depth_q != `VIC_RST_DEPTH && win.prio <= top.prio) begin
            cand.valid = 1'b0;
        end
    end

    // edge clear on the acknowledged source
    always_comb begin
        ack_clr = '0;
        if (nack && nsel.valid && !spur_q) begin
            ack_clr[nsel.src] = 1'b1;
        end
        if (fack && pend[0]) begin
            ack_clr[0] = 1'b1;
        end
    end

    // requests; both held off while spurious is open
    assign normal_request_line_o = cand.valid & ~spur_q;
    assign fast_request_line_o = pend[0] & ~spur_q;

    // bus answer, one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= acc;
        end
    end
    assign wb_ack_o = ack_q;

    // per-source mode and vector registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 32; i++) begin
                sense_q[i] <= `VIC_RST_SENSE;
                prio_q[i] <= `VIC_RST_PRIO;
                vec_q[i] <= `VIC_RST_WORD;
            end
        end else if (wr && off[8:7] == `VIC_RGN_MODE && wb_sel_i[0]) begin
            sense_q[sidx] <= wb_dat_i[`VIC_MODE_SENSE_LSB +: 2];
            prio_q[sidx] <= wb_dat_i[`VIC_MODE_PRIO_LSB +: 3];
        end else if (wr && off[8:7] == `VIC_RGN_VEC) begin
            vec_q[sidx] <= merge(vec_q[sidx], wb_dat_i, wb_sel_i);
        end
    end

    // spurious vector and protect enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            spur_vec_q <= `VIC_RST_WORD;
            protect_q <= 1'b0;
        end else if (wr && off == `VIC_OFF_SPV) begin
            spur_vec_q <= merge(spur_vec_q, wb_dat_i, wb_sel_i);
        end else if (wr && off == `VIC_OFF_PROT && wb_sel_i[0]) begin
            protect_q <= wb_dat_i[0];
        end
    end

    // mask: enable command sets, disable command clears
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_q <= `VIC_RST_WORD;
        end else if (wr && off == `VIC_OFF_ENA) begin
            mask_q <= mask_q | wb_dat_i;
        end else if (wr && off == `VIC_OFF_DIS) begin
            mask_q <= mask_q & ~wb_dat_i;
        end
    end

    // protect read memorizes the vector it returned
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_q <= '0;
        end else if (rd && is_ivp && protect_q) begin
            mem_q <= cand;
        end
    end

    // service stack and spurious state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 8; i++) begin
                stk_q[i] <= '0;
            end
            depth_q <= `VIC_RST_DEPTH;
            spur_q <= 1'b0;
        end else if (nack && !spur_q) begin
            if (nsel.valid) begin
                // push; in normal mode a push needs a strictly higher level so 8 never overflows; a protect write pushes mem_q unchecked
                stk_q[depth_q[2:0]] <= '{prio: nsel.prio, src: nsel.src};
                depth_q <= depth_q + 4'h1;
            end else begin
                spur_q <= 1'b1;
            end
        end else if (fack && !pend[0]) begin
            spur_q <= 1'b1;
        end else if (wr && off == `VIC_OFF_EOS) begin
            if (spur_q) begin
                spur_q <= 1'b0;
            end else if (depth_q != `VIC_RST_DEPTH) begin
                depth_q <= depth_q - 4'h1;
            end
        end
    end

    // read data, registered for the answer cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= `VIC_RST_WORD;
        end else if (rd) begin
            rdata_q <= `VIC_RST_WORD; // unmapped and reserved read zero
            if (off[8:7] == `VIC_RGN_MODE) begin
                rdata_q[`VIC_MODE_SENSE_LSB +: 2] <= sense_q[sidx];
                rdata_q[`VIC_MODE_PRIO_LSB +: 3] <= prio_q[sidx];
            end else if (off[8:7] == `VIC_RGN_VEC) begin
                rdata_q <= vec_q[sidx];
            end else begin
                unique case (off)
                    `VIC_OFF_IVP: begin
                        // spurious while open, or nothing may preempt
                        rdata_q <= (cand.valid && !spur_q) ? vec_q[cand.src]
                                                            : spur_vec_q;
                    end
                    `VIC_OFF_FVP: begin
                        rdata_q <= (pend[0] && !spur_q) ? vec_q[0] : spur_vec_q;
                    end
                    `VIC_OFF_CSS: begin
                        if (depth_q != `VIC_RST_DEPTH) begin
                            rdata_q[4:0] <= top.src;
                        end
                    end
                    `VIC_OFF_PEND: rdata_q <= active;
                    `VIC_OFF_MASK: rdata_q <= mask_q;
                    `VIC_OFF_CORE: begin
                        rdata_q[0] <= fast_request_line_o;
                        rdata_q[1] <= normal_request_line_o;
                    end
                    `VIC_OFF_SPV: rdata_q <= spur_vec_q;
                    `VIC_OFF_PROT: rdata_q[0] <= protect_q;
                    default: rdata_q <= `VIC_RST_WORD;
                endcase
            end
        end
    end
    assign wb_dat_o = rdata_q;
endmodule // vic_ctrl

/* File: tb/vic_core_model.sv */
module vic_core_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // request lines from the controller
    input wire logic normal_i,
    input wire logic fast_i,
    // requests as the core has taken them
    output logic normal_taken_o,
    output logic fast_taken_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // core samples both lines once a clock, so it sees them one cycle late
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            normal_taken_o <= 1'b0;
            fast_taken_o <= 1'b0;
        end else begin
            normal_taken_o <= normal_i;
            fast_taken_o <= fast_i;
        end
    end
endmodule // vic_core_model

/* File: tb/vic_ctrl_properties.sv */
module vic_ctrl_properties (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // sources and requests
    input wire logic [31:0] src_i,
    input wire logic normal_request_line_o,
    input wire logic fast_request_line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tk; // access taken this edge
    logic hit; // vector port hit with calm sources
    logic prot_q; // mirrored protect bit
    logic [31:0] s1_q, s2_q; // source history
    assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // a source change near the access may legally raise a request
    assign hit = wb_adr_i[8:2] == 7'h40 && src_i == s1_q && s1_q == s2_q;
    // protect bit mirror
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prot_q <= 1'b0;
        end else if (tk && wb_we_i && wb_sel_i[0] && wb_adr_i[8:2] == 7'h4E) begin
            prot_q <= wb_dat_i[0];
        end
    end
    // source history
    always_ff @(posedge clk_i) begin
        s1_q <= src_i;
        s2_q <= s1_q;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_norm_rd;
        tk && !wb_we_i && hit && !prot_q;
    endsequence
    sequence s_prot_rd;
        tk && !wb_we_i && hit && prot_q;
    endsequence
    sequence s_norm_wr;
        tk && wb_we_i && hit && !prot_q;
    endsequence
    a_ack_next: assert property (tk |=> wb_ack_o) else $error("no ack after access");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_reset_quiet: assert property ($fell(rst_i) |-> !wb_ack_o && !normal_request_line_o
        && !fast_request_line_o) else $error("activity right after reset");
    a_read_drops: assert property (s_norm_rd |=> src_i != s1_q
        || !normal_request_line_o) else $error("request kept after vector read");
    a_prot_read_keeps: assert property (s_prot_rd |=> src_i != s1_q
        || $stable(normal_request_line_o)) else $error("protect read changed request");
    a_vec_write_noop: assert property (s_norm_wr |=> src_i != s1_q
        || $stable(normal_request_line_o)) else $error("vector write acted");
    a_dat_holds: assert property (!(tk && !wb_we_i) |=> $stable(wb_dat_o))
        else $error("read data moved without read");
    a_unmapped_zero: assert property (tk && !wb_we_i && wb_adr_i[8:2] == 7'h46
        |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
endmodule // vic_ctrl_properties

/* File: tb/vectored_priority_interrupt_controller_bench.sv */
module vectored_priority_interrupt_controller_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, we = 1'b0;
    logic [31:0] adr = 32'h0, dw = 32'h0, src = 32'h0, dr, got;
    logic ack, nreq, freq, ntk, ftk;
    // reference model: vectors, levels, stack of serviced sources
    int vec[32], pri[32], stk[$], sv, fail_count = 0, compares = 0;
    logic [31:0] act = 32'h0, ena = 32'h0, edg = 32'h3, rnd = 32'h88D3;
    bit spur = 0;
    always #4 clk_i = ~clk_i;
    vic_ctrl u_vic_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dw), .wb_dat_o(dr),
        .wb_ack_o(ack), .src_i(src), .normal_request_line_o(nreq),
        .fast_request_line_o(freq));
    vic_core_model u_vic_core_model (.clk_i(clk_i), .rst_i(rst_i), .normal_i(nreq),
        .fast_i(freq), .normal_taken_o(ntk), .fast_taken_o(ftk));
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // best enabled source above the current level, -1 if none
    function automatic int win();
        int b = -1;
        for (int i = 1; i < 32; i++) begin
            if (act[i] && ena[i] && (stk.size() == 0 || pri[i] > pri[stk[$]])
                && (b < 0 || pri[i] > pri[b])) b = i;
        end
        return b;
    endfunction
    task automatic wrap_up();
        if (fail_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        compares++;
        if (s !== e) begin
            $display("MISMATCH %s expected %h seen %h", n, e, s);
            fail_count++;
        end
    endtask
    // one classic cycle, held until ack is sampled high
    task automatic bus(logic w, logic [8:0] a, logic [31:0] d);
        int n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= {23'h0, a};
        dw <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail_count++;
            wrap_up();
        end
        got = dr;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(logic [8:0] a, logic [31:0] e, string n);
        bus(1'b0, a, 32'h0);
        chk(n, e, got);
    endtask
    // settle, then compare the request the core has taken
    task automatic req();
        repeat (4) @(posedge clk_i);
        chk("normal", {31'h0, !spur && win() >= 0}, {31'h0, ntk});
    endtask
    // handler entry: vector read in normal mode
    task automatic ivp();
        int w = win();
        if (w < 0) spur = 1'b1;
        else stk.push_back(w);
        rd(9'h100, w < 0 ? sv : vec[w], "vector");
        if (w >= 0 && edg[w]) act[w] = 1'b0;
        rd(9'h108, stk.size() ? stk[$] : 0, "current");
        req();
    endtask
    task automatic eos();
        bus(1'b1, 9'h130, 32'h0);
        if (spur) spur = 1'b0;
        else if (stk.size()) void'(stk.pop_back());
        req();
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(9'h110, 32'h0, "mask");
        rd(9'h134, 32'h0, "spurious");
        rd(9'h084, 32'h0, "vector1");
        rd(9'h118, 32'h0, "unmapped");
        // random vectors and levels; 0 rising edge, 1 edge, rest level
        for (int i = 0; i < 10; i++) begin
            rnd = lfsr(rnd);
            vec[i] = rnd;
            pri[i] = rnd[2:0];
            bus(1'b1, 9'h080 + 9'(4 * i), rnd);
            bus(1'b1, 9'(4 * i), {25'h0, i == 0, i < 2, 2'h0, rnd[2:0]});
        end
        sv = lfsr(rnd);
        bus(1'b1, 9'h134, sv);
        ena = 32'h3FF;
        bus(1'b1, 9'h120, ena);
        rd(9'h110, ena, "mask");
        // random sets of level sources
        for (int r = 0; r < 12; r++) begin
            rnd = lfsr(rnd);
            src <= {22'h0, rnd[9:2], 2'h0};
            act = {22'h0, rnd[9:2], 2'h0};
            req();
            ivp();
            ivp();
            eos();
            eos();
            src <= 32'h0;
            act = 32'h0;
            req();
        end
        // nesting with the software source
        pri[1] = 5;
        pri[2] = 2;
        pri[4] = 7;
        bus(1'b1, 9'h004, 32'h25);
        bus(1'b1, 9'h008, 32'h2);
        bus(1'b1, 9'h010, 32'h7);
        src <= 32'h4;
        act = 32'h4;
        req();
        bus(1'b1, 9'h12C, 32'h2);
        act[1] = 1'b1;
        req();
        ivp();
        src <= 32'h14;
        act[4] = 1'b1;
        req();
        ivp();
        eos();
        eos();
        src <= 32'h0;
        act = 32'h0;
        bus(1'b1, 9'h12C, 32'h2);
        bus(1'b1, 9'h128, 32'h2);
        req();
        // disabled source stays silent
        bus(1'b1, 9'h124, 32'h4);
        ena[2] = 1'b0;
        src <= 32'h4;
        act = 32'h4;
        rd(9'h110, ena, "mask");
        req();
        // fast path
        src <= 32'h1;
        req();
        chk("fast", 32'h1, {31'h0, ftk});
        rd(9'h104, vec[0], "fast vector");
        req();
        chk("fast", 32'h0, {31'h0, ftk});
        rd(9'h104, sv, "fast spurious");
        spur = 1'b1;
        req();
        eos();
        // protect mode, then a plain vector write
        bus(1'b1, 9'h138, 32'h1);
        src <= 32'h8;
        act = 32'h8;
        req();
        rd(9'h100, vec[3], "protect vector");
        rd(9'h108, 32'h0, "protect current");
        req();
        bus(1'b1, 9'h100, 32'h0);
        stk.push_back(3);
        rd(9'h108, 32'h3, "acked current");
        req();
        eos();
        bus(1'b1, 9'h138, 32'h0);
        bus(1'b1, 9'h100, 32'h0);
        rd(9'h108, 32'h0, "idle current");
        req();
        ivp();
        eos();
        wrap_up();
    end
    // watchdog
    initial begin
        repeat (40000) @(posedge clk_i);
        fail_count++;
        wrap_up();
    end
endmodule // vectored_priority_interrupt_controller_bench
bind vic_ctrl vic_ctrl_properties u_vic_ctrl_properties (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .src_i(src_i), .normal_request_line_o(normal_request_line_o),
    .fast_request_line_o(fast_request_line_o));
